// [design/dcp_consts.svh]
// register map, field positions and reset values of the drawing coprocessor
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH
// coprocessor space (paddr bit 8 low), byte = index * 4
`define DCP_A_CVA 12'h010
`define DCP_A_LENA 12'h030
`define DCP_A_LENB 12'h034
`define DCP_A_CTRL 12'h044
`define DCP_A_VMCTL 12'h048
`define DCP_A_ERR 12'h080
`define DCP_A_KTERM 12'h084
`define DCP_A_DIR 12'h088
`define DCP_A_PIXOP 12'h08c
`define DCP_A_DIM 12'h090
`define DCP_A_SRC 12'h0a0
// i/o space (paddr bit 8 high)
`define DCP_A_PORTA 12'h100
`define DCP_A_PORTB 12'h104
`define DCP_A_IEN 12'h108
`define DCP_A_ISTS 12'h10c
`define DCP_A_FMT 12'h110
`define DCP_IO_BIT 8
`define DCP_WSTEP 12'h004
`define DCP_NPTR 3
`define DCP_PTR_DST 2
// control register bits
`define DCP_CTL_BUSY 7
`define DCP_CTL_TERM 5
`define DCP_CTL_PAUSED 4
`define DCP_CTL_PAUSE 3
`define DCP_CTL_SR 1
// interrupt status / enable bits
`define DCP_IS_DONE 0
`define DCP_IS_REJ 1
// save state lengths in words (8 words, 32 bytes in all)
`define DCP_LEN_A 3'h4
`define DCP_LEN_B 3'h4
`define DCP_NWORD 4
// reset values
`define DCP_W0 32'h0000_0000
`define DCP_CNT0 3'h0
`define DCP_IS0 2'h0
`define DCP_REM1 32'h0000_0001
`endif

// [design/dcp_pkg.sv]
// types shared by the drawing coprocessor control block
package dcp_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10,
		ST_HALT = 2'b11
	} dcp_state_t;
	// pointer word: y in the high half, x in the low half
	typedef struct packed {
		logic [15:0] y;
		logic [15:0] x;
	} dcp_ptr_t;
	// pixel operation word; pat_sel 0 means fixed foreground
	typedef struct packed {
		logic [23:0] spare;
		logic line;
		logic src_fg;
		logic src_bg;
		logic [1:0] pat_sel;
		logic [2:0] spare_lo;
	} dcp_pixop_t;
endpackage

// [design/dcp_op_control.sv]
// operation control, status and state save/restore of the drawing coprocessor
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "dcp_consts.svh"

module dcp_op_control (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// host interrupt
	output logic irq_o
);

	// bus handshake
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q, wd, raw;
	logic acc, wr, rd, hit, noswap;
	// engine
	dcp_pkg::dcp_state_t state_q;
	dcp_pkg::dcp_pixop_t pixop_q;
	logic [31:0] rem_q, dir_q, k_q, err_q, e_inc;
	dcp_pkg::dcp_ptr_t ptr_q [`DCP_NPTR];
	logic [`DCP_NPTR-1:0] adv;
	logic busy, paused, step, done_ev, start;
	// control, config, status
	logic pause_q, sr_q, term_q, fmt_q, irq_q, rej_ev, soft_rst;
	logic [31:0] vmctl_q;
	logic [15:0] dim_q;
	logic [1:0] ien_q, ists_q, ists_clr;
	// save / restore: eight words in all, well under the state limit
	logic [2:0] sa_q, sb_q;
	logic xfer_ok, a_go, b_go, save_done, rest_done;
	logic [31:0] a_word [`DCP_NWORD];
	logic [31:0] b_word [`DCP_NWORD];

	// byte lane reversal between the two register formats
	function automatic logic [31:0] bswap(input logic [31:0] v);
		bswap = {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction
	// a transfer takes effect at the edge where pready is seen high
	assign acc = psel_i & penable_i & pready_q;
	assign wr = acc & pwrite_i;
	assign rd = acc & ~pwrite_i;
	// direction and pixel-op words keep their order: it steers the op
	assign noswap = (paddr_i == `DCP_A_PIXOP) | (paddr_i == `DCP_A_DIR);
	assign wd = (fmt_q & ~noswap) ? bswap(pwdata_i) : pwdata_i;
	// engine status seen by software
	assign busy = (state_q != dcp_pkg::ST_IDLE);
	assign paused = (state_q == dcp_pkg::ST_HALT);
	assign step = (state_q == dcp_pkg::ST_DATA);
	assign done_ev = step & (rem_q == `DCP_REM1);
	assign start = wr & (paddr_i == `DCP_A_PIXOP) & pstrb_i[3] & ~busy;
	// a write into coprocessor space while running, control excepted
	assign rej_ev = wr & ~paddr_i[`DCP_IO_BIT] & busy
		& (paddr_i != `DCP_A_CTRL);
	// state words in the order they leave and return through the ports
	assign a_word[0] = ptr_q[0];
	assign a_word[1] = ptr_q[1];
	assign a_word[2] = ptr_q[2];
	assign a_word[3] = err_q;
	assign b_word[0] = rem_q;
	assign b_word[1] = pixop_q;
	assign b_word[2] = dir_q;
	assign b_word[3] = k_q;
	// ports move data only while paused and halted or idle
	assign xfer_ok = pause_q & (paused | ~busy);
	assign a_go = acc & (paddr_i == `DCP_A_PORTA) & xfer_ok
		& (pwrite_i == ~sr_q) & (sa_q < `DCP_LEN_A);
	assign b_go = acc & (paddr_i == `DCP_A_PORTB) & xfer_ok
		& (pwrite_i == ~sr_q) & (sb_q < `DCP_LEN_B);
	assign save_done = sr_q & (sa_q == `DCP_LEN_A)
		& (sb_q == `DCP_LEN_B);
	assign rest_done = ~sr_q & (sa_q == `DCP_LEN_A)
		& (sb_q == `DCP_LEN_B);
	assign soft_rst = term_q | save_done;
	// pointer advance enables per operand
	assign adv[0] = pixop_q.src_fg | pixop_q.src_bg;
	assign adv[1] = (pixop_q.pat_sel != 2'h0);
	assign adv[2] = 1'b1;
	// bresenham step: k1 in the low half, k2 in the high half
	assign e_inc = err_q[31] ? {{16{k_q[15]}}, k_q[15:0]}
		: {{16{k_q[31]}}, k_q[31:16]};
	// status clear mask from a write of ones
	assign ists_clr = (wr & (paddr_i == `DCP_A_ISTS)) ? wd[1:0] : 2'h0;
	// read mux; write-only registers answer zero
	always_comb
	begin
		raw = `DCP_W0;
		hit = 1'b1;
		case (paddr_i)
			`DCP_A_CVA: raw = ptr_q[`DCP_PTR_DST];
			`DCP_A_LENA: raw = {29'h0, `DCP_LEN_A};
			`DCP_A_LENB: raw = {29'h0, `DCP_LEN_B};
			`DCP_A_CTRL:
			begin
				raw[`DCP_CTL_BUSY] = busy;
				raw[`DCP_CTL_TERM] = term_q;
				raw[`DCP_CTL_PAUSED] = paused;
				raw[`DCP_CTL_PAUSE] = pause_q;
				raw[`DCP_CTL_SR] = sr_q;
			end
			`DCP_A_VMCTL: raw = vmctl_q;
			`DCP_A_ERR: raw = err_q;
			`DCP_A_SRC: raw = ptr_q[0];
			`DCP_A_SRC + `DCP_WSTEP: raw = ptr_q[1];
			`DCP_A_SRC + `DCP_WSTEP + `DCP_WSTEP: raw = ptr_q[2];
			`DCP_A_PORTA: raw = (xfer_ok & sr_q & (sa_q < `DCP_LEN_A))
				? a_word[sa_q[1:0]] : `DCP_W0;
			`DCP_A_PORTB: raw = (xfer_ok & sr_q & (sb_q < `DCP_LEN_B))
				? b_word[sb_q[1:0]] : `DCP_W0;
			`DCP_A_IEN: raw = {30'h0, ien_q};
			`DCP_A_ISTS: raw = {30'h0, ists_q};
			`DCP_A_FMT: raw = {31'h0, fmt_q};
			`DCP_A_KTERM, `DCP_A_DIR, `DCP_A_PIXOP, `DCP_A_DIM:
				raw = `DCP_W0;
			default: hit = 1'b0;
		endcase
	end

	// apb answer one cycle into the access phase, data and error with it
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= `DCP_W0;
		end
		else
		begin
			pready_q <= psel_i & penable_i & ~pready_q;
			if (psel_i & penable_i & ~pready_q)
			begin
				pslverr_q <= ~hit;
				prdata_q <= pwrite_i ? `DCP_W0
					: ((fmt_q & ~noswap) ? bswap(raw) : raw);
			end
			else
				pslverr_q <= 1'b0;
		end
	end

	// control register: pause, save/restore select, terminate
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst)
		begin
			pause_q <= 1'b0;
			sr_q <= 1'b0;
			term_q <= 1'b0;
		end
		else if (wr & (paddr_i == `DCP_A_CTRL))
		begin
			pause_q <= wd[`DCP_CTL_PAUSE];
			sr_q <= wd[`DCP_CTL_SR];
			term_q <= wd[`DCP_CTL_TERM];
		end
	end

	// engine: a step is one address plus one data memory cycle;
	// pausing is checked only between cycles so none is cut short
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst)
			state_q <= dcp_pkg::ST_IDLE;
		else
		begin
			case (state_q)
				dcp_pkg::ST_IDLE:
				begin
					if (rest_done)
						state_q <= dcp_pkg::ST_HALT;
					else if (start)
						state_q <= dcp_pkg::ST_ADDR;
				end
				dcp_pkg::ST_ADDR:
				begin
					if (pause_q)
						state_q <= dcp_pkg::ST_HALT;
					else
						state_q <= dcp_pkg::ST_DATA;
				end
				dcp_pkg::ST_DATA:
				begin
					if (rem_q == `DCP_REM1)
						state_q <= dcp_pkg::ST_IDLE;
					else
						state_q <= dcp_pkg::ST_ADDR;
				end
				dcp_pkg::ST_HALT:
				begin
					if (~pause_q & (rem_q != `DCP_W0))
						state_q <= dcp_pkg::ST_ADDR;
					else if (~pause_q)
						state_q <= dcp_pkg::ST_IDLE;
				end
				default: state_q <= dcp_pkg::ST_IDLE;
			endcase
		end
	end

	// remaining step count, state part b word 0
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst)
			rem_q <= `DCP_W0;
		else if (b_go & ~sr_q & (sb_q == 3'h0))
			rem_q <= wd;
		else if (start)
			rem_q <= {15'h0, {1'b0, dim_q} + 17'h1};
		else if (step)
			rem_q <= rem_q - `DCP_REM1;
	end

	// operation words of part b; writes while running are still stored
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst)
		begin
			pixop_q <= `DCP_W0;
			dir_q <= `DCP_W0;
			k_q <= `DCP_W0;
		end
		else if (b_go & ~sr_q)
		begin
			if (sb_q == 3'h1)
				pixop_q <= wd;
			if (sb_q == 3'h2)
				dir_q <= wd;
			if (sb_q == 3'h3)
				k_q <= wd;
		end
		else if (wr)
		begin
			if (paddr_i == `DCP_A_PIXOP)
				pixop_q <= wd;
			if (paddr_i == `DCP_A_DIR)
				dir_q <= wd;
			if (paddr_i == `DCP_A_KTERM)
				k_q <= wd;
		end
	end

	// line error term, part a word 3
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst)
			err_q <= `DCP_W0;
		else if (a_go & ~sr_q & (sa_q == 3'h3))
			err_q <= wd;
		else if (wr & (paddr_i == `DCP_A_ERR))
			err_q <= wd;
		else if (step & pixop_q.line)
			err_q <= err_q + e_inc;
	end

	// map pointers: source, pattern, destination
	genvar gi;
	generate
		for (gi = 0; gi < `DCP_NPTR; gi++)
		begin : g_ptr
			always_ff @(posedge sys_clk_i)
			begin
				if (rst_i | soft_rst)
					ptr_q[gi] <= `DCP_W0;
				else if (a_go & ~sr_q & (sa_q == 3'(gi)))
					ptr_q[gi] <= wd;
				else if (wr & (paddr_i == 12'(`DCP_A_SRC + 4 * gi)))
					ptr_q[gi] <= wd;
				else if (step & adv[gi] & dir_q[0])
					ptr_q[gi].y <= ptr_q[gi].y + 16'h1;
				else if (step & adv[gi])
					ptr_q[gi].x <= ptr_q[gi].x + 16'h1;
			end
		end
	endgenerate

	// port word counters; a control write starts a fresh transfer
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst | rest_done
			| (wr & (paddr_i == `DCP_A_CTRL)))
		begin
			sa_q <= `DCP_CNT0;
			sb_q <= `DCP_CNT0;
		end
		else
		begin
			if (a_go)
				sa_q <= sa_q + 3'h1;
			if (b_go)
				sb_q <= sb_q + 3'h1;
		end
	end

	// plain configuration: format select survives a soft reset
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			fmt_q <= 1'b0;
		else if (wr & (paddr_i == `DCP_A_FMT))
			fmt_q <= wd[0];
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst)
		begin
			vmctl_q <= `DCP_W0;
			dim_q <= 16'h0;
		end
		else if (wr)
		begin
			if (paddr_i == `DCP_A_VMCTL)
				vmctl_q <= wd;
			if (paddr_i == `DCP_A_DIM)
				dim_q <= wd[15:0];
		end
	end

	// interrupt enables; terminate masks them all
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i | soft_rst)
			ien_q <= `DCP_IS0;
		else if (wr & (paddr_i == `DCP_A_IEN))
			ien_q <= wd[1:0];
	end

	// sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			ists_q <= `DCP_IS0;
		else
		begin
			ists_q[`DCP_IS_DONE] <= done_ev
				| (ists_q[`DCP_IS_DONE] & ~ists_clr[`DCP_IS_DONE]);
			ists_q[`DCP_IS_REJ] <= rej_ev
				| (ists_q[`DCP_IS_REJ] & ~ists_clr[`DCP_IS_REJ]);
		end
	end

	// interrupt line follows status and enable one cycle later
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			irq_q <= 1'b0;
		else
			irq_q <= |(ists_q & ien_q);
	end

	// outputs straight from flip-flops
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign irq_o = irq_q;

endmodule

// [testbench/dcp_op_control_chk.sv]
// port assertions of the coprocessor control block
`timescale 1ns/10ps
`include "dcp_consts.svh"

module dcp_op_control_chk (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// apb slave side
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// host interrupt
	input wire logic irq_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	// every access is answered after exactly one wait state
	a_ready_one_wait: assert property (
		psel_i && penable_i && !$past(penable_i) |=> pready_o)
		else $error("answer not in second access cycle");
	a_ready_in_access: assert property (
		pready_o |-> psel_i && penable_i)
		else $error("ready outside an access phase");
	a_ready_one_cycle: assert property (pready_o |=> !pready_o)
		else $error("ready held longer than one cycle");
	// length registers read four words in either byte order
	a_len_value: assert property (
		pready_o && !pwrite_i && paddr_i inside {`DCP_A_LENA, `DCP_A_LENB}
		|-> prdata_o inside {32'h0000_0004, 32'h0400_0000})
		else $error("wrong state length");
	a_wo_read_zero: assert property (
		pready_o && !pwrite_i && paddr_i inside {`DCP_A_KTERM,
		`DCP_A_DIR, `DCP_A_PIXOP, `DCP_A_DIM} |-> prdata_o == 32'h0)
		else $error("write-only register readable");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_err_data_zero: assert property (
		pslverr_o |-> prdata_o == 32'h0)
		else $error("unmapped read returned data");
	// terminate word is the same in both byte orders
	a_term_masks_irq: assert property (
		pready_o && pwrite_i && paddr_i == `DCP_A_CTRL &&
		pwdata_i == 32'h2000_0020 |-> ##3 !irq_o [*4])
		else $error("interrupt not masked after terminate");
endmodule

// [testbench/dcp_host_model.sv]
// apb host processor model issuing register transfers
`timescale 1ns/10ps

module dcp_host_model (
	// clock
	input wire logic sys_clk_i,
	// apb requests
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o,
	output logic [3:0] pstrb_o,
	// apb answers
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	// idle bus at time zero
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
		pstrb_o = 4'hf;
	end

	// one whole word per transfer; only the bench timeout ends a wait
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge sys_clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge sys_clk_i);
		penable_o <= 1'b1;
		do
			@(posedge sys_clk_i);
		while (pready_i !== 1'b1);
		q = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// released lines show no stale value
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
endmodule

// [testbench/dcp_op_control_tb.sv]
// self-checking bench of the coprocessor control block
`timescale 1ns/10ps
`include "dcp_consts.svh"
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin bad_count++; \
$display("ERROR t=%0t got %h exp %h", $time, g, x); end end

module dcp_op_control_tb;
	typedef struct packed {
		logic wr;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic er;
	} dcp_row_t;
	localparam logic [11:0] pat_adr = `DCP_A_SRC + `DCP_WSTEP;
	localparam logic [11:0] dst_adr = pat_adr + `DCP_WSTEP;
	localparam logic [31:0] len4 = {29'h0, `DCP_LEN_A};
	// plain accesses after reset: write, read back, expected word
	localparam dcp_row_t rows [16] = '{
		'{1'b0, `DCP_A_LENA, 32'h0, len4, 1'b0},
		'{1'b0, `DCP_A_LENB, 32'h0, len4, 1'b0},
		'{1'b0, `DCP_A_CTRL, 32'h0, 32'h0, 1'b0},
		'{1'b0, `DCP_A_ISTS, 32'h0, 32'h0, 1'b0},
		'{1'b0, `DCP_A_IEN, 32'h0, 32'h0, 1'b0},
		'{1'b0, `DCP_A_DIR, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h1f0, 32'h0, 32'h0, 1'b1},
		'{1'b1, 12'h1f0, 32'h5, 32'h0, 1'b1},
		'{1'b1, `DCP_A_VMCTL, 32'h1234_5678, 32'h1234_5678, 1'b0},
		'{1'b1, `DCP_A_DIM, 32'h7, 32'h0, 1'b0},
		'{1'b1, `DCP_A_KTERM, 32'hfffe_0001, 32'h0, 1'b0},
		'{1'b1, `DCP_A_ERR, 32'h0, 32'h0, 1'b0},
		'{1'b1, `DCP_A_SRC, 32'h0003_0004, 32'h0003_0004, 1'b0},
		'{1'b1, pat_adr, 32'h0005_0006, 32'h0005_0006, 1'b0},
		'{1'b1, dst_adr, 32'h0010_0020, 32'h0010_0020, 1'b0},
		'{1'b0, `DCP_A_CVA, 32'h0, 32'h0010_0020, 1'b0}};
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb;
	logic [31:0] sv [8];
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;

	dcp_op_control i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.irq_o(irq));
	dcp_host_model i_host (.sys_clk_i(sys_clk_i), .psel_o(psel),
		.penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata),
		.pready_i(pready), .pslverr_i(pslverr));

	task wr(input logic [11:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, q, e);
	endtask
	task rd(input logic [11:0] a);
		i_host.xfer(1'b0, a, 32'h0, q, e);
	endtask
	// bounded wait for the interrupt line to reach a level
	task wait_irq(input logic lv);
		for (int n = 0; n < 200 && irq !== lv; n++)
			@(posedge sys_clk_i);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// clock and hang guard
	initial
		forever #4 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			bad_count++;
			end_sim();
		end
	end

	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		`CHK(irq, 1'b0)
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			`CHK({e, q}, {rows[i].er, rows[i].x})
		end
		// line draw of eight steps, with a forbidden write meanwhile
		wr(`DCP_A_ISTS, 32'h3);
		wr(`DCP_A_IEN, 32'h1);
		wr(`DCP_A_PIXOP, 32'h0000_0080);
		rd(`DCP_A_CTRL);
		`CHK(q[`DCP_CTL_BUSY], 1'b1)
		wr(`DCP_A_VMCTL, 32'h0);
		`CHK(e, 1'b0)
		wait_irq(1'b1);
		`CHK(irq, 1'b1)
		rd(`DCP_A_ISTS);
		`CHK(q[1:0], 2'h3)
		rd(`DCP_A_CTRL);
		`CHK(q[`DCP_CTL_BUSY], 1'b0)
		rd(`DCP_A_VMCTL);
		`CHK(q, 32'h0)
		rd(`DCP_A_ERR);
		`CHK(q, 32'hffff_ffff)
		rd(`DCP_A_SRC);
		`CHK(q, 32'h0003_0004)
		rd(pat_adr);
		`CHK(q, 32'h0005_0006)
		rd(dst_adr);
		`CHK(q, 32'h0010_0028)
		wr(`DCP_A_ISTS, 32'h0);
		rd(`DCP_A_ISTS);
		`CHK(q[1:0], 2'h3)
		wr(`DCP_A_ISTS, 32'h1);
		rd(`DCP_A_ISTS);
		`CHK(q[1:0], 2'h2)
		wait_irq(1'b0);
		`CHK(irq, 1'b0)
		wr(`DCP_A_IEN, 32'h2);
		wait_irq(1'b1);
		`CHK(irq, 1'b1)
		wr(`DCP_A_ISTS, 32'h2);
		wait_irq(1'b0);
		`CHK(irq, 1'b0)
		// pause mid-run, save, restore and resume
		wr(`DCP_A_PIXOP, 32'h0000_0048);
		wr(`DCP_A_CTRL, 32'h0000_000a);
		for (int n = 0; n < 40 && q[`DCP_CTL_PAUSED] !== 1'b1; n++)
			rd(`DCP_A_CTRL);
		`CHK(q[`DCP_CTL_PAUSED], 1'b1)
		rd(`DCP_A_ISTS);
		`CHK(q[1:0], 2'h0)
		for (int i = 0; i < 8; i++)
		begin
			rd(i < `DCP_NWORD ? `DCP_A_PORTA : `DCP_A_PORTB);
			sv[i] = q;
		end
		`CHK(sv[0], 32'h0003_0006)
		`CHK(sv[1], 32'h0005_0008)
		`CHK(sv[2], 32'h0010_002a)
		`CHK({sv[3], sv[4]}, {32'hffff_ffff, 32'h6})
		`CHK({sv[5], sv[6], sv[7]}, {32'h48, 32'h0, 32'hfffe_0001})
		rd(`DCP_A_CTRL);
		`CHK(q, 32'h0)
		rd(`DCP_A_IEN);
		`CHK(q, 32'h0)
		wr(`DCP_A_CTRL, 32'h0000_0008);
		for (int i = 0; i < 8; i++)
			wr(i < `DCP_NWORD ? `DCP_A_PORTA : `DCP_A_PORTB, sv[i]);
		rd(`DCP_A_CTRL);
		`CHK({q[7], q[4]}, 2'b11)
		wr(`DCP_A_IEN, 32'h1);
		wr(`DCP_A_ISTS, 32'h3);
		wr(`DCP_A_CTRL, 32'h0);
		wait_irq(1'b1);
		`CHK(irq, 1'b1)
		rd(`DCP_A_CTRL);
		`CHK({q[7], q[4]}, 2'b00)
		rd(`DCP_A_ISTS);
		`CHK(q[1:0], 2'h1)
		rd(dst_adr);
		`CHK(q, 32'h0010_0030)
		// terminate a running draw
		wr(`DCP_A_ISTS, 32'h3);
		wr(`DCP_A_DIM, 32'h7);
		wr(`DCP_A_PIXOP, 32'h0000_0080);
		wr(`DCP_A_CTRL, 32'h2000_0020);
		rd(`DCP_A_CTRL);
		`CHK(q, 32'h0)
		rd(`DCP_A_IEN);
		`CHK(q, 32'h0)
		// alternate byte order
		wr(`DCP_A_FMT, 32'h0100_0001);
		rd(`DCP_A_LENA);
		`CHK(q, 32'h0400_0000)
		wr(`DCP_A_VMCTL, 32'h1122_3344);
		rd(`DCP_A_VMCTL);
		`CHK(q, 32'h1122_3344)
		// direction word keeps its order: one y step in alternate format
		wr(`DCP_A_DIR, 32'h0000_0001);
		wr(`DCP_A_PIXOP, 32'h0);
		rd(`DCP_A_CVA);
		`CHK(q, 32'h0000_0100)
		wr(`DCP_A_FMT, 32'h0);
		rd(`DCP_A_VMCTL);
		`CHK(q, 32'h4433_2211)
		// reset while idle with an interrupt pending
		wr(`DCP_A_IEN, 32'h1);
		wait_irq(1'b1);
		`CHK(irq, 1'b1)
		rst_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		`CHK(irq, 1'b0)
		rd(`DCP_A_ISTS);
		`CHK(q, 32'h0)
		end_sim();
	end
endmodule

bind dcp_op_control dcp_op_control_chk i_chk (.sys_clk_i(sys_clk_i),
	.rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .irq_o(irq_o));
